// ### hw/lrm_consts.svh
// constants for the legacy region map decoder
`ifndef LRM_CONSTS_SVH
`define LRM_CONSTS_SVH
`define LRM_OFF_MAP        16'h8004
`define LRM_OFF_INT_STAT   16'h8010
`define LRM_OFF_INT_CLR    16'h8014
`define LRM_OFF_INT_EN     16'h8018
`define LRM_MAP_RESET      32'h0000_0000
`define LRM_MAP_WMASK      32'h1f7f_8000
`define LRM_BIT_UP_ROUTE   28
`define LRM_FLD_UP_HI      27
`define LRM_FLD_UP_LO      24
`define LRM_BIT_PCI_REG    22
`define LRM_BIT_A20_MASK   21
`define LRM_BIT_LO_ROUTE   20
`define LRM_FLD_LO_HI      19
`define LRM_FLD_LO_LO      16
`define LRM_BIT_TRAP       15
`define LRM_RC_PCI         3
`define LRM_RC_CACHE       2
`define LRM_RC_WRITE       1
`define LRM_RC_READ        0
`define LRM_SEG_LO_BASE    17'h0b000
`define LRM_SEG_LO_TOP     17'h0b7ff
`define LRM_SEG_UP_BASE    17'h0b800
`define LRM_SEG_UP_TOP     17'h0bfff
`define LRM_PORT_LO        16'h03d0
`define LRM_PORT_HI        16'h03df
`define LRM_A20            20
`define LRM_NUM_EV         3
`define LRM_EV_TRAP        0
`define LRM_EV_PCI_DENY    1
`define LRM_EV_FWD         2
`endif

// ### hw/lrm_pkg.sv
// types shared by the legacy region map decoder
package lrm_pkg;
    typedef enum logic [1:0] {
        LRM_DST_MEM = 2'b00,
        LRM_DST_GFX = 2'b01,
        LRM_DST_PCIM = 2'b11,
        LRM_DST_NONE = 2'b10
    } lrm_dst_t;

    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic        write;
        logic        smm;
        logic        from_pci;
        logic [31:0] addr;
    } lrm_req_t;

    typedef struct packed {
        logic        valid;
        lrm_dst_t    dest;
        logic        cacheable;
        logic        smi;
        logic        pci_reg_ok;
        logic [31:0] addr;
    } lrm_rsp_t;
endpackage : lrm_pkg

// ### hw/lrm_decoder.sv
// legacy region map decoder: map register, access steering, traps
// Function
// RQ1 - upper route bit sends B8000h segment reads and writes to graphics pipeline
// RQ2 - upper routed segment is uncacheable; its cache-enable bit is ignored
// RQ3 - bits 27:24 control region B8000h to BFFFFh
// RQ4 - bit 22 gates PCI slave access to internal registers
// RQ5 - bit 21 forces address bit 20 low except in system-management mode
// RQ6 - lower route bit sends lower video segment accesses to graphics pipeline
// RQ7 - lower routed segment is uncacheable; its cache-enable bit is ignored
// RQ8 - bits 19:16 control region B0000h to B7FFFh
// RQ9 - bit 15 raises system-management interrupt on I/O ports 3D0h-3DFh
// RQ10 - field bit 3 lets PCI slave in only with matching read/write enable
// RQ11 - field bit 2 clear inhibits caching of the region
// RQ12 - field bit 1 clear forwards writes to the PCI master
// RQ13 - field bit 0 clear forwards reads to the PCI master
// RQ14 - write permission checked after cache; cached writes update regardless
// RQ15 - controls sit at offset 8004h and reset to zero
`timescale 1ns/1ps
`include "lrm_consts.svh"

module lrm_decoder
    import lrm_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire lrm_req_t          acc_req,
    output lrm_rsp_t               acc_rsp,
    output logic                   smi_out,
    output logic                   irq
);

    // elaboration checks on what the fixed-width logic below can serve
    initial begin
        if (ADDR_W < 16) begin
            $error("lrm_decoder: ADDR_W must be at least 16");
        end
        if (`LRM_NUM_EV != 3) begin
            $error("lrm_decoder: read padding assumes three event bits");
        end
        if ((`LRM_FLD_UP_HI - `LRM_FLD_UP_LO) != 3) begin
            $error("lrm_decoder: upper region field must be four bits");
        end
        if ((`LRM_FLD_LO_HI - `LRM_FLD_LO_LO) != 3) begin
            $error("lrm_decoder: lower region field must be four bits");
        end
        if (`LRM_SEG_LO_TOP >= `LRM_SEG_UP_BASE) begin
            $error("lrm_decoder: video segments must not overlap");
        end
        if ((`LRM_MAP_RESET & ~`LRM_MAP_WMASK) != 32'h0000_0000) begin
            $error("lrm_decoder: map reset sets a reserved bit");
        end
        if (`LRM_PORT_LO > `LRM_PORT_HI) begin
            $error("lrm_decoder: trap port range is empty");
        end
        if (`LRM_A20 > 31) begin
            $error("lrm_decoder: masked address bit out of range");
        end
        if (`LRM_BIT_UP_ROUTE > 31) begin
            $error("lrm_decoder: route bit out of range");
        end
    end

    // state held by the block
    logic [31:0]               map_q;
    logic [`LRM_NUM_EV-1:0]    stat_q;
    logic [`LRM_NUM_EV-1:0]    en_q;
    logic [31:0]               rdata_q;
    logic                      rsp_valid_q;
    lrm_dst_t                  rsp_dest_q;
    logic                      rsp_cache_q;
    logic                      rsp_smi_q;
    logic                      rsp_preg_q;
    logic [31:0]               rsp_addr_q;
    logic                      smi_q;

    // register offset compare; upper offset bits must be clear
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    // inclusive range check on the 16-byte granular legacy address index
    function automatic logic in_seg(input logic [31:0] a, input logic [16:0] lo,
                                    input logic [16:0] hi);
        in_seg = (a[31:4] >= {11'h000, lo}) && (a[31:4] <= {11'h000, hi});
    endfunction : in_seg

    // map register; reserved bits never store so they read zero
    // software may write reserved bits freely without side effects
    always_ff @(posedge clk) begin
        if (!resetn) begin
            map_q <= `LRM_MAP_RESET; // RQ15
        end else if (reg_wr && hit(reg_addr, `LRM_OFF_MAP)) begin
            map_q <= reg_wdata & `LRM_MAP_WMASK; // RQ15
        end
    end

    // interrupt enable register; only the low event bits exist
    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_q <= '0;
        end else if (reg_wr && hit(reg_addr, `LRM_OFF_INT_EN)) begin
            en_q <= reg_wdata[`LRM_NUM_EV-1:0];
        end
    end

    // route enables of the two video segments
    logic       up_route;
    logic       lo_route;
    assign up_route = map_q[`LRM_BIT_UP_ROUTE]; // RQ1
    assign lo_route = map_q[`LRM_BIT_LO_ROUTE]; // RQ6

    // region control fields of the two video segments
    logic [3:0] up_fld;
    logic [3:0] lo_fld;
    assign up_fld   = map_q[`LRM_FLD_UP_HI:`LRM_FLD_UP_LO]; // RQ3
    assign lo_fld   = map_q[`LRM_FLD_LO_HI:`LRM_FLD_LO_LO]; // RQ8

    // bit-20 mask is live only outside system-management mode
    logic a20_forced;
    assign a20_forced = map_q[`LRM_BIT_A20_MASK] && !acc_req.smm; // RQ5

    // effective address after the bit-20 mask; smm accesses see it untouched
    logic [31:0] eff_addr;
    always_comb begin
        eff_addr = acc_req.addr;
        if (a20_forced) begin
            eff_addr[`LRM_A20] = 1'b0; // RQ5
        end
    end

    // segment decode on the masked address, memory cycles only
    logic is_mem;
    logic in_lo;
    logic in_up;
    assign is_mem = !acc_req.is_io;
    assign in_lo  = is_mem && in_seg(eff_addr, `LRM_SEG_LO_BASE, `LRM_SEG_LO_TOP);
    assign in_up  = is_mem && in_seg(eff_addr, `LRM_SEG_UP_BASE, `LRM_SEG_UP_TOP);

    // the lower route bit is taken to cover the lower segment it is named for
    logic routed;
    assign routed = (in_up && up_route) || (in_lo && lo_route); // RQ1 RQ6

    // either video segment falls under a region control field
    logic in_fld;
    assign in_fld = in_up || in_lo;

    // the two segments never overlap, so one select picks the field
    logic [3:0] fld;
    assign fld = in_up ? up_fld : lo_fld; // RQ3 RQ8

    // control bits of the selected field, named once for every user below
    logic fld_pci;
    logic fld_cache;
    logic fld_wr;
    logic fld_rd;
    assign fld_pci   = fld[`LRM_RC_PCI];   // RQ10
    assign fld_cache = fld[`LRM_RC_CACHE]; // RQ11
    assign fld_wr    = fld[`LRM_RC_WRITE]; // RQ12
    assign fld_rd    = fld[`LRM_RC_READ];  // RQ13

    // access permission from the region field
    logic rw_ok;
    logic pci_ok;
    assign rw_ok  = acc_req.write ? fld_wr : fld_rd; // RQ12 RQ13
    assign pci_ok = fld_pci && rw_ok; // RQ10

    // destination; a denied slave cycle goes nowhere rather than loop back to pci
    lrm_dst_t dest;
    logic     pci_deny;
    always_comb begin
        dest     = LRM_DST_MEM;
        pci_deny = 1'b0;
        if (acc_req.is_io) begin
            dest = LRM_DST_NONE;
        end else if (routed) begin
            dest = LRM_DST_GFX; // RQ1 RQ6
        end else if (in_fld) begin
            if (acc_req.from_pci && !pci_ok) begin
                dest     = LRM_DST_NONE; // RQ10
                pci_deny = 1'b1;
            end else if (!rw_ok) begin
                dest = LRM_DST_PCIM; // RQ12 RQ13
            end
        end
    end

    // cacheability is judged ahead of write permission, so a cached
    // line takes write data even when the region is read-only
    logic cache_ok;
    always_comb begin
        cache_ok = 1'b1;
        if (acc_req.is_io) begin
            cache_ok = 1'b0;
        end else if (routed) begin
            cache_ok = 1'b0; // RQ2 RQ7
        end else if (in_fld) begin
            cache_ok = fld_cache; // RQ11 RQ14
        end
        // slave cycles never fill the core cache
        if (acc_req.from_pci) begin
            cache_ok = 1'b0;
        end
    end

    // inclusive port range check for the video port trap
    function automatic logic in_ports(input logic [31:0] a);
        in_ports = (a[15:0] >= `LRM_PORT_LO) && (a[15:0] <= `LRM_PORT_HI);
    endfunction : in_ports

    // video port trap decode; only the low 16 address bits carry an io port
    logic trap;
    always_comb begin
        trap = 1'b0;
        if (acc_req.valid && acc_req.is_io && map_q[`LRM_BIT_TRAP]) begin
            trap = in_ports(acc_req.addr); // RQ9
        end
    end

    // answer valid, exactly one cycle after the request
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= acc_req.valid;
        end
    end

    // answer destination
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_dest_q <= LRM_DST_MEM;
        end else begin
            rsp_dest_q <= dest; // RQ1 RQ6 RQ10 RQ12 RQ13
        end
    end

    // answer cacheability
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_cache_q <= 1'b0;
        end else begin
            rsp_cache_q <= cache_ok; // RQ2 RQ7 RQ11
        end
    end

    // answer trap flag
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_smi_q <= 1'b0;
        end else begin
            rsp_smi_q <= trap; // RQ9
        end
    end

    // answer register gate, a plain copy of the map bit
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_preg_q <= 1'b0;
        end else begin
            rsp_preg_q <= map_q[`LRM_BIT_PCI_REG]; // RQ4
        end
    end

    // answer address after the bit-20 mask
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_addr_q <= 32'h0000_0000;
        end else begin
            rsp_addr_q <= eff_addr; // RQ5
        end
    end

    // smi pulse for the trapped port access
    always_ff @(posedge clk) begin
        if (!resetn) begin
            smi_q <= 1'b0;
        end else begin
            smi_q <= trap; // RQ9
        end
    end

    // event sources for the sticky status bits
    logic [`LRM_NUM_EV-1:0] ev;
    always_comb begin
        ev                   = '0;
        ev[`LRM_EV_TRAP]     = trap;
        ev[`LRM_EV_PCI_DENY] = acc_req.valid && pci_deny;
        ev[`LRM_EV_FWD]      = acc_req.valid && (dest == LRM_DST_PCIM);
    end

    // write-one-to-clear strobe; the clear register itself stores nothing
    logic [`LRM_NUM_EV-1:0] clr;
    always_comb begin
        clr = '0;
        if (reg_wr && hit(reg_addr, `LRM_OFF_INT_CLR)) begin
            clr = reg_wdata[`LRM_NUM_EV-1:0];
        end
    end

    // sticky event bits; a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~clr) | ev;
        end
    end

    // read mux; the clear register and unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (hit(reg_addr, `LRM_OFF_MAP)) begin
            rd_mux = map_q; // RQ15
        end else if (hit(reg_addr, `LRM_OFF_INT_STAT)) begin
            rd_mux = {29'h0000_0000, stat_q};
        end else if (hit(reg_addr, `LRM_OFF_INT_EN)) begin
            rd_mux = {29'h0000_0000, en_q};
        end
    end

    // read data stands for the one cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= '0;
        end
    end

    // registered outputs straight from their flip-flops
    assign reg_rdata = rdata_q;
    assign smi_out   = smi_q;
    assign acc_rsp   = '{valid:      rsp_valid_q,
                         dest:       rsp_dest_q,
                         cacheable:  rsp_cache_q,
                         smi:        rsp_smi_q,
                         pci_reg_ok: rsp_preg_q,
                         addr:       rsp_addr_q};

    // level interrupt, high while any enabled status bit is set
    assign irq       = |(stat_q & en_q);

endmodule : lrm_decoder

// ### dv/lrm_decoder_assertions.sv
// port checker for the legacy region map decoder
`timescale 1ns/1ps
`include "lrm_consts.svh"
module lrm_decoder_assertions
    import lrm_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire lrm_req_t          acc_req,
    input wire lrm_rsp_t          acc_rsp,
    input wire logic              smi_out,
    input wire logic              irq
);
    logic [31:0] map_q;
    logic [31:0] ma;
    logic [3:0]  fld;
    logic        rt;
    logic        ok;
    logic        inb;
    // shadow map, so the checker needs no view inside
    always_ff @(posedge clk) begin
        if (!resetn) map_q <= 32'h0;
        else if (reg_wr && reg_addr == `LRM_OFF_MAP) map_q <= reg_wdata & `LRM_MAP_WMASK;
    end
    // mask bit 20 first, then pick the segment
    always_comb begin
        ma = acc_req.addr;
        if (map_q[21] && !acc_req.smm) ma[20] = 1'b0;
        inb = acc_req.valid && !acc_req.is_io && ma[31:16] == 16'h000b;
        fld = ma[15] ? map_q[27:24] : map_q[19:16];
        rt = ma[15] ? map_q[28] : map_q[20];
        ok = acc_req.write ? fld[1] : fld[0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_cpu_hit;
        inb && !acc_req.from_pci;
    endsequence
    sequence s_port_hit;
        acc_req.valid && acc_req.is_io && acc_req.addr[31:4] == 28'h3d;
    endsequence
    a_route_gfx: assert property (s_cpu_hit ##0 rt |=>
        acc_rsp.dest == LRM_DST_GFX && !acc_rsp.cacheable) else $error("route lost");
    a_denied_fwd: assert property (s_cpu_hit ##0 !rt && !ok |=>
        acc_rsp.dest == LRM_DST_PCIM) else $error("not forwarded");
    a_cache_off: assert property (s_cpu_hit ##0 !fld[2] |=>
        !acc_rsp.cacheable) else $error("cached");
    a_pci_denied: assert property (inb && acc_req.from_pci && !rt && !(fld[3] && ok) |=>
        acc_rsp.dest == LRM_DST_NONE) else $error("pci let in");
    a_addr_mask: assert property (acc_req.valid && map_q[21] && !acc_req.smm |=>
        !acc_rsp.addr[20]) else $error("bit 20 high");
    a_pci_reg: assert property (acc_req.valid |=>
        acc_rsp.pci_reg_ok == $past(map_q[22])) else $error("reg gate");
    a_port_trap: assert property (s_port_hit |=> smi_out == $past(map_q[15]))
        else $error("trap");
    a_map_read: assert property (reg_rd && reg_addr == `LRM_OFF_MAP |=>
        reg_rdata == $past(map_q)) else $error("map read");
endmodule : lrm_decoder_assertions

bind lrm_decoder lrm_decoder_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_req, .acc_rsp,
    .smi_out, .irq);

// ### dv/lrm_core_model.sv
// core and pci slave model issuing decoder requests
`timescale 1ns/1ps
module lrm_core_model
    import lrm_pkg::*;
(
    input wire logic clk,
    output lrm_req_t acc_req
);
    lrm_req_t idle;
    initial acc_req = '0;
    // one cycle per request, then a gap; released fields flip
    task automatic issue(input lrm_req_t r);
        idle = ~r;
        idle.valid = 1'b0;
        acc_req <= r;
        @(posedge clk);
        acc_req <= idle;
        @(posedge clk);
    endtask : issue
endmodule : lrm_core_model

// ### dv/testbench.sv
// self-checking bench for the legacy region map decoder
`timescale 1ns/1ps
`include "lrm_consts.svh"
module testbench
    import lrm_pkg::*;
;
    typedef struct packed {
        logic [31:0] addr;
        lrm_dst_t    dst;
        logic        dc, cc, cache, smi, pok;
    } lrm_exp_t;
    logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic [15:0] reg_addr = 16'h0;
    logic [31:0] reg_wdata = 32'h0, m = 32'h0, s, reg_rdata;
    lrm_req_t    acc_req, r;
    lrm_rsp_t    acc_rsp;
    logic        smi_out, irq;
    lrm_exp_t    e, qa[$];
    logic [31:0] qr[$];
    int          errors = 0, total_checks = 0, seed = 37797;
    always #12.5 clk = ~clk;
    lrm_decoder dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .acc_req, .acc_rsp, .smi_out, .irq);
    lrm_core_model core (.clk, .acc_req);
    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    // each strobe is followed by an idle edge, so no signal is set twice at once
    task wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task rd(input logic [15:0] a, input logic [31:0] x);
        qr.push_back(x);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : rd
    // expectation built from the map value, never from the outputs
    function automatic lrm_exp_t expect_of(input logic [31:0] mp, input lrm_req_t q);
        lrm_exp_t x;
        logic [3:0] f;
        logic rt, ok;
        x = '0; x.addr = q.addr; x.dst = LRM_DST_NONE; x.pok = mp[22];
        if (mp[21] && !q.smm) x.addr[20] = 1'b0;
        x.smi = q.is_io && mp[15] && q.addr[31:4] == 28'h3d;
        x.dc = q.is_io;
        f = x.addr[15] ? mp[27:24] : mp[19:16];
        rt = x.addr[15] ? mp[28] : mp[20];
        ok = q.write ? f[1] : f[0];
        if (!q.is_io && x.addr[31:16] == 16'h000b) begin
            x.dc = 1'b1;
            x.cc = 1'b1;
            if (rt) x.dst = LRM_DST_GFX;
            else if (q.from_pci && !(f[3] && ok)) x.dst = LRM_DST_NONE;
            else begin
                x.dst = ok ? LRM_DST_MEM : LRM_DST_PCIM;
                x.cache = f[2] && !q.from_pci;
            end
        end else if (!q.is_io) begin
            x.dc = 1'b1;
            x.cc = 1'b1;
            x.dst = LRM_DST_MEM;
            x.cache = !q.from_pci;
        end
        return x;
    endfunction : expect_of
    task acc(input lrm_req_t q);
        qa.push_back(expect_of(m, q));
        core.issue(q);
    endtask : acc
    task irq_is(input logic x);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, x});
        @(posedge clk);
    endtask : irq_is
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // watcher pops the oldest note when an answer shows up
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (rd_d) chk(reg_rdata, qr.pop_front());
        if (acc_rsp.valid === 1'b1) begin
            e = qa.pop_front();
            chk(acc_rsp.addr, e.addr);
            if (e.dc) chk({30'h0, acc_rsp.dest}, {30'h0, e.dst});
            if (e.cc) chk({31'h0, acc_rsp.cacheable}, {31'h0, e.cache});
            chk({31'h0, smi_out}, {31'h0, e.smi});
            chk({31'h0, acc_rsp.pci_reg_ok}, {31'h0, e.pok});
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(`LRM_OFF_MAP, 32'h0);
        for (int i = 0; i < 96; i++) begin
            if (i % 12 == 0) begin
                m = $random(seed);
                wr(`LRM_OFF_MAP, m);
                m &= `LRM_MAP_WMASK;
                rd(`LRM_OFF_MAP, m);
            end
            s = $random(seed);
            r = '0; r.valid = 1'b1; r.write = s[2]; r.smm = s[3]; r.from_pci = s[4];
            r.is_io = s[1:0] == 2'd3;
            case (s[1:0])
                2'd0: r.addr = 32'h000b_0000 + {17'h0, s[30:16]};
                2'd1: r.addr = 32'h000b_8000 + {17'h0, s[30:16]};
                2'd2: r.addr = 32'h001b_8000 + {17'h0, s[30:16]};
                default: r.addr = 32'h0000_03c8 + {27'h0, s[20:16]};
            endcase
            acc(r);
        end
        // interrupt raised, masked, cleared
        wr(`LRM_OFF_INT_CLR, 32'h7); wr(`LRM_OFF_INT_EN, 32'h1);
        wr(`LRM_OFF_MAP, 32'h8000); m = 32'h8000;
        r = '0; r.valid = 1'b1; r.is_io = 1'b1; r.addr = 32'h3df;
        acc(r);
        irq_is(1'b1);
        rd(`LRM_OFF_INT_STAT, 32'h1); rd(`LRM_OFF_INT_CLR, 32'h0); rd(16'h8020, 32'h0);
        wr(`LRM_OFF_INT_EN, 32'h0); irq_is(1'b0);
        wr(`LRM_OFF_INT_EN, 32'h1); irq_is(1'b1);
        wr(`LRM_OFF_INT_CLR, 32'h1); irq_is(1'b0);
        rd(`LRM_OFF_INT_STAT, 32'h0);
        for (int k = 0; k < 8 && (qa.size() + qr.size()) > 0; k++) @(posedge clk);
        if ((qa.size() + qr.size()) > 0) errors++;
        end_of_test();
    end
endmodule : testbench
